// ### dv/integer_add_and_frame_alloc_bench.sv
// Self-checking bench for the add, pointer add and frame datapath.
`timescale 1ns/10ps
module integer_add_and_frame_alloc_bench;
    logic        i_clock = 1'b0;   // Free-running 100 MHz clock.
    logic        i_rst = 1'b1;     // Synchronous reset, active high.
    logic        i_valid = 1'b0;   // Instruction issue strobe.
    logic [1:0]  i_op = 2'h0;      // Operation selector.
    logic [1:0]  i_form = 2'h0;    // Operand form selector.
    logic        i_increment_variant = 1'b0;    // Extra one.
    logic        i_qualifying_predicate = 1'b0; // Predicate value.
    logic        i_pred_is_zero = 1'b1;         // Predicate is reg 0.
    logic        i_single_step = 1'b0;          // Single-step enable.
    logic [6:0]  i_target_sel = 7'h00, i_src3_sel = 7'h00; // Selectors.
    logic [63:0] i_src2 = 64'h0, i_src3 = 64'h0, i_saved_state = 64'h0;
    logic        i_src2_nat = 1'b0, i_src3_nat = 1'b0;     // Deferred bits.
    logic [13:0] i_short_immediate = 14'h0;   // Short immediate.
    logic [21:0] i_long_immediate = 22'h0;    // Long immediate.
    logic [6:0]  i_size_in = 7'h0, i_size_local = 7'h0; // Frame sizes.
    logic [6:0]  i_size_out = 7'h0, i_size_rot = 7'h0;  // Frame sizes.
    logic        o_wr_en, o_wr_nat, o_frame_update;     // Result flags.
    logic        o_illegal_op, o_single_step_trap;      // Event pulses.
    logic [6:0]  o_wr_sel, o_frame_size, o_local_size;  // Result fields.
    logic [63:0] o_wr_data;        // Result data.
    logic [3:0]  o_rot_groups;     // Rotating groups.
    logic [63:0] lfsr = 64'h4f;    // Random source, starts at 79.
    logic [63:0] e_data = 64'h0;   // Model of the held result data.
    logic [6:0]  e_sel = 7'h0, e_frame = 7'h0, e_local = 7'h0; // Held.
    logic [3:0]  e_rot = 4'h0;     // Model of rotating groups.
    logic        e_nat = 1'b0;     // Model of the held deferred bit.
    int          num_errors = 0;   // Mismatches seen.
    int          samples_checked = 0; // Comparisons made.
    int          cycles = 0;       // Clock cycles since start.

    // Clock of 10 ns period.
    always #5 i_clock = ~i_clock;

    // Device under test.
    integer_add_and_frame_alloc u_integer_add_and_frame_alloc (
        .i_clock(i_clock), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op),
        .i_form(i_form), .i_increment_variant(i_increment_variant),
        .i_qualifying_predicate(i_qualifying_predicate),
        .i_pred_is_zero(i_pred_is_zero), .i_single_step(i_single_step),
        .i_target_sel(i_target_sel), .i_src3_sel(i_src3_sel),
        .i_src2(i_src2), .i_src2_nat(i_src2_nat), .i_src3(i_src3),
        .i_src3_nat(i_src3_nat), .i_short_immediate(i_short_immediate),
        .i_long_immediate(i_long_immediate), .i_size_in(i_size_in),
        .i_size_local(i_size_local), .i_size_out(i_size_out),
        .i_size_rot(i_size_rot), .i_saved_state(i_saved_state),
        .o_wr_en(o_wr_en), .o_wr_sel(o_wr_sel), .o_wr_data(o_wr_data),
        .o_wr_nat(o_wr_nat), .o_frame_size(o_frame_size),
        .o_local_size(o_local_size), .o_rot_groups(o_rot_groups),
        .o_frame_update(o_frame_update), .o_illegal_op(o_illegal_op),
        .o_single_step_trap(o_single_step_trap)
    );

    // Cuts a hung run short; the ceiling is far above the test length.
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            test_done();
        end
    end

    // Galois shift register producing the next random word.
    function automatic logic [63:0] rnd();
        lfsr = lfsr[0] ? ((lfsr >> 1) ^ 64'hd800000000000000) : (lfsr >> 1);
        return lfsr;
    endfunction : rnd

    // Compares result data.
    task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t data got %h exp %h", $time, got, exp);
        end
    endtask : check_word

    // Compares the packed flags, selector and frame sizes.
    task automatic check_ctrl(input logic [29:0] got, input logic [29:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t ctrl got %h exp %h", $time, got, exp);
        end
    endtask : check_ctrl

    // Checks every output against the model with the given pulses.
    task automatic check_all(input logic wr, ill, trap, upd);
        check_word(o_wr_data, e_data);
        check_ctrl({o_wr_en, o_illegal_op, o_single_step_trap, o_frame_update,
                    o_wr_nat, o_wr_sel, o_frame_size, o_local_size,
                    o_rot_groups}, {wr, ill, trap, upd, e_nat, e_sel, e_frame,
                    e_local, e_rot});
    endtask : check_all

    // Issues one instruction with random operands and checks its answer.
    task automatic issue(input logic [1:0] op, input logic [1:0] form,
                         input logic inc, input logic pred, input logic pz,
                         input logic [6:0] sel3);
        logic [63:0] src1;  // First operand after form selection.
        logic [63:0] sum;   // Raw sum.
        logic        ill;   // Expected illegal outcome.
        int          sof;   // Requested frame size.
        int          sol;   // Requested local size.
        i_op = op;
        i_form = form;
        i_increment_variant = inc;
        i_qualifying_predicate = pred;
        i_pred_is_zero = pz;
        i_src3_sel = sel3;
        i_src2 = rnd();
        i_src3 = rnd();
        {i_src2_nat, i_src3_nat, i_single_step} = 3'(rnd());
        {i_short_immediate, i_long_immediate, i_target_sel} = 43'(rnd());
        i_saved_state = rnd();
        i_valid = 1'b1;
        sof = int'(i_size_in) + int'(i_size_local) + int'(i_size_out);
        sol = int'(i_size_in) + int'(i_size_local);
        src1 = (form == 2'h0) ? i_src2 : (form == 2'h1) ?
               {{50{i_short_immediate[13]}}, i_short_immediate} :
               {{42{i_long_immediate[21]}}, i_long_immediate};
        ill = (form == 2'h3) || (op == 2'h3) || (inc && form != 2'h0) ||
              (op == 2'h1 && form == 2'h2) || (form == 2'h2 && sel3 > 7'h3) ||
              (op == 2'h2 && (sof > 96 || int'(i_size_rot) > sof ||
              sol > sof || i_size_rot[2:0] != 3'h0 || !pz));
        sum = src1 + i_src3 + ((op == 2'h0 && inc) ? 64'h1 : 64'h0);
        @(posedge i_clock);
        #1;
        if (pred && !ill)
        begin
            e_sel = i_target_sel;
            e_nat = (op != 2'h2)
                    && ((form == 2'h0 && i_src2_nat) || i_src3_nat);
            e_data = (op == 2'h0) ? sum : (op == 2'h1) ?
                     {1'b0, i_src3[31:30], 29'h0, sum[31:0]} : i_saved_state;
            if (op == 2'h2)
            begin
                e_frame = sof[6:0];
                e_local = sol[6:0];
                e_rot = i_size_rot[6:3];
            end
        end
        check_all(pred && !ill, pred && ill, pred && i_single_step,
                  pred && !ill && op == 2'h2);
    endtask : issue

    // Lowers the issue strobe for one cycle and checks that nothing moves.
    task automatic idle();
        i_valid = 1'b0;
        @(posedge i_clock);
        #1;
        check_all(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : idle

    // Sets the four allocation sizes.
    task automatic sizes(input logic [6:0] a, b, c, d);
        {i_size_in, i_size_local, i_size_out, i_size_rot} = {a, b, c, d};
    endtask : sizes

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Main sequence: reset, then each instruction family back to back.
    initial
    begin
        repeat (16) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        idle();
        for (int k = 0; k < 24; k++)
            issue(2'h0, 2'(k % 3), (k % 3 == 0) && k[1], 1'b1, 1'b1,
                  7'(k & 3));
        for (int k = 0; k < 12; k++)
            issue(2'h1, 2'(k%2), k[2], 1'b1, 1'b1, 7'h9);
        idle();
        issue(2'h3, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        issue(2'h0, 2'h3, 1'b0, 1'b1, 1'b1, 7'h0);
        issue(2'h0, 2'h1, 1'b1, 1'b1, 1'b1, 7'h0);
        issue(2'h0, 2'h2, 1'b1, 1'b1, 1'b1, 7'h1);
        issue(2'h1, 2'h2, 1'b0, 1'b1, 1'b1, 7'h0);
        issue(2'h0, 2'h2, 1'b0, 1'b1, 1'b1, 7'h4);
        issue(2'h0, 2'h0, 1'b1, 1'b0, 1'b1, 7'h0);
        sizes(7'h02, 7'h03, 7'h04, 7'h08);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        sizes(7'h20, 7'h20, 7'h20, 7'h60);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        sizes(7'h01, 7'h00, 7'h01, 7'h00);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 7'h0);
        issue(2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 7'h0);
        sizes(7'h28, 7'h28, 7'h11, 7'h00);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        sizes(7'h04, 7'h04, 7'h00, 7'h10);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        sizes(7'h08, 7'h04, 7'h04, 7'h04);
        issue(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 7'h0);
        idle();
        test_done();
    end
endmodule : integer_add_and_frame_alloc_bench

// ### inc/int_add_pkg.sv
// Package with encodings and limits for the integer add and frame datapath.
package int_add_pkg;
    // Operation selector values.
    localparam logic [1:0] OP_ADD         = 2'h0;
    localparam logic [1:0] OP_POINTER_ADD = 2'h1;
    localparam logic [1:0] OP_ALLOC       = 2'h2;
    // First operand form selector values.
    localparam logic [1:0] FORM_REG       = 2'h0;
    localparam logic [1:0] FORM_SHORT     = 2'h1;
    localparam logic [1:0] FORM_LONG      = 2'h2;
    // Immediate field widths.
    localparam int SHORT_IMM_W = 14;
    localparam int LONG_IMM_W  = 22;
    // Register selector widths.
    localparam int REG_SEL_W   = 7;
    localparam int LONG_SEL_W  = 2;
    // Frame limits.
    localparam logic [6:0] MAX_FRAME  = 7'h60;
    localparam int         ROT_SHIFT  = 3;
    // Pointer add field positions.
    localparam int PTR_SRC_HI = 31;
    localparam int PTR_SRC_LO = 30;
    localparam int PTR_DST_HI = 62;
    localparam int PTR_DST_LO = 61;
    // Reset values of the frame state.
    localparam logic [6:0] FRAME_RESET = 7'h00;
endpackage : int_add_pkg

// ### src/integer_add_and_frame_alloc.sv
// Execution datapath for add, pointer add and frame allocation.
`timescale 1ns/10ps
// Function
// RULE1 - Add two operands, optionally plus one.
// RULE2 - Sign-extend 14 or 22 bit immediates.
// RULE3 - Long immediate form selects registers 0-3.
// RULE4 - Increment only allowed in register form.
// RULE5 - Result deferred bit ORs source bits.
// RULE6 - False predicate leaves state unchanged.
// RULE7 - Pointer add clears upper 32 bits.
// RULE8 - Pointer add copies bits 31:30 to 62:61.
// RULE9 - Pointer add has register or short form.
// RULE10 - Allocate writes saved state to target.
// RULE11 - New frame size takes effect immediately.
// RULE12 - Frame size is inputs plus locals plus outputs.
// RULE13 - Local size is inputs plus locals.
// RULE14 - Inputs and locals treated identically.
// RULE15 - Allocate may grow or shrink frame.
// RULE16 - Allocate takes four size parameters.
// RULE17 - Single-step trap applies to every instruction; the code raises it only when the qualifying predicate is true.
// RULE18 - Illegal operation on oversize frame or predicate.
// RULE19 - Rotating size multiple of eight, within frame.
// RULE20 - Sums wrap with no carry flag.
// RULE21 - Frame state commits with target write.
module integer_add_and_frame_alloc #(
    parameter int DATA_W = 64                 // Register data width.
) (
    input  wire logic              i_clock,             // System clock.
    input  wire logic              i_rst,               // Sync reset.
    input  wire logic              i_valid,             // Instruction issue.
    input  wire logic [1:0]        i_op,                // Operation select.
    input  wire logic [1:0]        i_form,              // Operand form.
    input  wire logic              i_increment_variant, // Add one more.
    input  wire logic              i_qualifying_predicate, // Predicate value.
    input  wire logic              i_pred_is_zero,      // Predicate is reg 0.
    input  wire logic              i_single_step,       // Single-step enable.
    input  wire logic [6:0]        i_target_sel,        // Target register.
    input  wire logic [6:0]        i_src3_sel,          // Second source sel.
    input  wire logic [DATA_W-1:0] i_src2,              // First reg operand.
    input  wire logic              i_src2_nat,          // Its deferred bit.
    input  wire logic [DATA_W-1:0] i_src3,              // Second operand.
    input  wire logic              i_src3_nat,          // Its deferred bit.
    input  wire logic [13:0]       i_short_immediate,   // 14-bit immediate.
    input  wire logic [21:0]       i_long_immediate,    // 22-bit immediate.
    input  wire logic [6:0]        i_size_in,           // Input region size.
    input  wire logic [6:0]        i_size_local,        // Local region size.
    input  wire logic [6:0]        i_size_out,          // Output region size.
    input  wire logic [6:0]        i_size_rot,          // Rotating size.
    input  wire logic [DATA_W-1:0] i_saved_state,       // Saved caller state.
    output logic                   o_wr_en,             // Target write pulse.
    output logic [6:0]             o_wr_sel,            // Target register.
    output logic [DATA_W-1:0]      o_wr_data,           // Result data.
    output logic                   o_wr_nat,            // Result deferred bit.
    output logic [6:0]             o_frame_size,        // Current frame size.
    output logic [6:0]             o_local_size,        // Current local size.
    output logic [3:0]             o_rot_groups,        // Rotating size / 8.
    output logic                   o_frame_update,      // Frame commit pulse.
    output logic                   o_illegal_op,        // Illegal op pulse.
    output logic                   o_single_step_trap   // Step trap pulse.
);

    // Elaboration check: the pointer add layout needs 64 bits.
    if (DATA_W != 64)
    begin : g_bad_width
        $error("DATA_W must be 64");
    end

    // Combinational next values.
    logic              next_wr_en;
    logic [6:0]        next_wr_sel;
    logic [DATA_W-1:0] next_wr_data;
    logic              next_wr_nat;
    logic [6:0]        next_frame_size;
    logic [6:0]        next_local_size;
    logic [3:0]        next_rot_groups;
    logic              next_frame_update;
    logic              next_illegal_op;
    logic              next_single_step_trap;

    // Working values of the datapath.
    logic [DATA_W-1:0] first_op;      // Selected first operand.
    logic              first_nat;     // Deferred bit of first operand.
    logic [DATA_W-1:0] sum;           // Wrapped sum.
    logic [7:0]        sof_wide;      // Frame size with headroom.
    logic [7:0]        sol_wide;      // Local size with headroom.
    logic              bad_form;      // Operand form unusable.
    logic              bad_alloc;     // Frame request illegal.

    // Select operand, add and decode faults for the issued instruction.
    always_comb
    begin
        first_op  = i_src2;
        first_nat = i_src2_nat;
        bad_form  = 1'b0;
        // Immediates are sign-extended and carry no deferred bit.
        case (i_form)
            int_add_pkg::FORM_REG:
            begin
                first_op  = i_src2;
                first_nat = i_src2_nat;
            end
            int_add_pkg::FORM_SHORT:
            begin
                first_op  = {{(DATA_W-14){i_short_immediate[13]}},
                             i_short_immediate}; // RULE2
                first_nat = 1'b0; // RULE5
            end
            int_add_pkg::FORM_LONG:
            begin
                first_op  = {{(DATA_W-22){i_long_immediate[21]}},
                             i_long_immediate}; // RULE2
                first_nat = 1'b0; // RULE5
                // The long form reaches only registers zero to three.
                bad_form  = (i_src3_sel[6:2] != 5'h00) // RULE3
                    || (i_op != int_add_pkg::OP_ADD); // RULE9
            end
            default:
            begin
                bad_form = 1'b1;
            end
        endcase
        // Increment is meaningful only with two register operands.
        if (i_increment_variant && (i_form != int_add_pkg::FORM_REG))
        begin
            bad_form = 1'b1; // RULE4
        end
        // Sum wraps modulo two to the width; no carry is kept.
        sum = first_op + i_src3
            + {{(DATA_W-1){1'b0}}, (i_increment_variant
                && i_op == int_add_pkg::OP_ADD)}; // RULE1 RULE20
        // Inputs and locals simply add; no distinction is made.
        sof_wide = {1'b0, i_size_in} + {1'b0, i_size_local}
            + {1'b0, i_size_out}; // RULE12 RULE14 RULE16
        sol_wide = {1'b0, i_size_in} + {1'b0, i_size_local}; // RULE13
        bad_alloc = (sof_wide > {1'b0, int_add_pkg::MAX_FRAME})
            || ({1'b0, i_size_rot} > sof_wide)
            || (sol_wide > sof_wide)
            || (i_size_rot[2:0] != 3'h0)
            || !i_pred_is_zero; // RULE18 RULE19
    end

    // Compute the next outputs and frame state.
    always_comb
    begin
        next_wr_en            = 1'b0;
        next_wr_sel           = o_wr_sel;
        next_wr_data          = o_wr_data;
        next_wr_nat           = o_wr_nat;
        next_frame_size       = o_frame_size;
        next_local_size       = o_local_size;
        next_rot_groups       = o_rot_groups;
        next_frame_update     = 1'b0;
        next_illegal_op       = 1'b0;
        next_single_step_trap = 1'b0;
        // A false predicate leaves all state as it was.
        if (i_valid && i_qualifying_predicate) // RULE6
        begin
            next_single_step_trap = i_single_step; // RULE17
            case (i_op)
                int_add_pkg::OP_ADD:
                begin
                    // Plain add writes the sum and merged deferred bit.
                    if (bad_form)
                    begin
                        next_illegal_op = 1'b1;
                    end
                    else
                    begin
                        next_wr_en   = 1'b1; // RULE1
                        next_wr_sel  = i_target_sel;
                        next_wr_data = sum;
                        next_wr_nat  = first_nat | i_src3_nat; // RULE5
                    end
                end
                int_add_pkg::OP_POINTER_ADD:
                begin
                    // Pointer add keeps the low word and region bits.
                    if (bad_form)
                    begin
                        next_illegal_op = 1'b1; // RULE9
                    end
                    else
                    begin
                        next_wr_en   = 1'b1;
                        next_wr_sel  = i_target_sel;
                        next_wr_data = {1'b0, i_src3[31:30], 29'h0,
                                        sum[31:0]}; // RULE7 RULE8
                        next_wr_nat  = first_nat | i_src3_nat; // RULE5
                    end
                end
                int_add_pkg::OP_ALLOC:
                begin
                    // Allocate writes the saved state and new frame.
                    if (bad_alloc)
                    begin
                        next_illegal_op = 1'b1; // RULE18
                    end
                    else
                    begin
                        next_wr_en        = 1'b1; // RULE10 RULE21
                        next_wr_sel       = i_target_sel;
                        next_wr_data      = i_saved_state; // RULE10
                        next_wr_nat       = 1'b0;
                        // Any size up or down is taken as it is.
                        next_frame_size   = sof_wide[6:0]; // RULE11 RULE15
                        next_local_size   = sol_wide[6:0]; // RULE13
                        next_rot_groups   =
                            i_size_rot[6:int_add_pkg::ROT_SHIFT]; // RULE19
                        next_frame_update = 1'b1; // RULE21
                    end
                end
                default:
                begin
                    next_illegal_op = 1'b1;
                end
            endcase
        end
    end

    // Register every output; reset clears the frame state.
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_wr_en            <= 1'b0;
            o_wr_sel           <= 7'h00;
            o_wr_data          <= '0;
            o_wr_nat           <= 1'b0;
            o_frame_size       <= int_add_pkg::FRAME_RESET;
            o_local_size       <= int_add_pkg::FRAME_RESET;
            o_rot_groups       <= 4'h0;
            o_frame_update     <= 1'b0;
            o_illegal_op       <= 1'b0;
            o_single_step_trap <= 1'b0;
        end
        else
        begin
            o_wr_en            <= next_wr_en;
            o_wr_sel           <= next_wr_sel;
            o_wr_data          <= next_wr_data;
            o_wr_nat           <= next_wr_nat;
            o_frame_size       <= next_frame_size;
            o_local_size       <= next_local_size;
            o_rot_groups       <= next_rot_groups;
            o_frame_update     <= next_frame_update;
            o_illegal_op       <= next_illegal_op;
            o_single_step_trap <= next_single_step_trap;
        end
    end

    // Checks on the datapath behaviour.
    chk_pred_false_quiet: assert property ( // RULE6
        @(posedge i_clock) disable iff (i_rst)
        (i_valid && !i_qualifying_predicate) |=> !o_wr_en && !o_illegal_op)
        else $error("false predicate changed state");
    chk_add_sum_value: assert property ( // RULE1
        @(posedge i_clock) disable iff (i_rst)
        (i_valid && i_qualifying_predicate && i_op == int_add_pkg::OP_ADD
         && i_form == int_add_pkg::FORM_REG)
        |=> o_wr_data == $past(i_src2) + $past(i_src3)
            + {63'h0, $past(i_increment_variant)})
        else $error("register add sum wrong");
    chk_short_sign_ext: assert property ( // RULE2
        @(posedge i_clock) disable iff (i_rst)
        (i_valid && i_qualifying_predicate && i_op == int_add_pkg::OP_ADD
         && i_form == int_add_pkg::FORM_SHORT && !i_increment_variant)
        |=> o_wr_data == {{50{$past(i_short_immediate[13])}},
            $past(i_short_immediate)} + $past(i_src3))
        else $error("short immediate add wrong");
    chk_incr_imm_bad: assert property ( // RULE4
        @(posedge i_clock) disable iff (i_rst)
        (i_valid && i_qualifying_predicate && i_increment_variant
         && i_op == int_add_pkg::OP_ADD && i_form != int_add_pkg::FORM_REG)
        |=> o_illegal_op && !o_wr_en)
        else $error("increment accepted with immediate");
    chk_nat_merge: assert property ( // RULE5
        @(posedge i_clock) disable iff (i_rst)
        (o_wr_en && !o_frame_update) |->
        o_wr_nat == (($past(i_form) == int_add_pkg::FORM_REG
            && $past(i_src2_nat)) || $past(i_src3_nat)))
        else $error("deferred bit wrong");
    chk_ptr_upper_bits: assert property ( // RULE7 RULE8
        @(posedge i_clock) disable iff (i_rst)
        (i_valid && i_qualifying_predicate
         && i_op == int_add_pkg::OP_POINTER_ADD && !bad_form)
        |=> o_wr_data[63] == 1'b0 && o_wr_data[60:32] == 29'h0
            && o_wr_data[62:61] == $past(i_src3[31:30]))
        else $error("pointer add upper bits wrong");
    chk_alloc_commit: assert property ( // RULE10 RULE12 RULE21
        @(posedge i_clock) disable iff (i_rst)
        o_frame_update |-> o_wr_en && o_wr_data == $past(i_saved_state)
            && o_frame_size == $past(i_size_in) + $past(i_size_local)
               + $past(i_size_out))
        else $error("allocate commit wrong");
    chk_alloc_limit: assert property ( // RULE18 RULE19
        @(posedge i_clock) disable iff (i_rst)
        o_frame_update |-> o_frame_size <= int_add_pkg::MAX_FRAME
            && o_local_size <= o_frame_size
            && {o_rot_groups, 3'h0} <= o_frame_size)
        else $error("frame limits broken");
    chk_step_trap: assert property ( // RULE17
        @(posedge i_clock) disable iff (i_rst)
        (i_valid && i_qualifying_predicate && i_single_step)
        |=> o_single_step_trap)
        else $error("single-step trap missing");

endmodule : integer_add_and_frame_alloc
